// [common/pio_consts.svh]
// register offsets, reset values and pin masks for the parallel i/o block
// assumes a 12-bit apb byte address and 8-bit ports in the low data bits
`ifndef PIO_CONSTS_SVH
`define PIO_CONSTS_SVH

// page zero: data at +0, direction at +4, one 8-byte pair per port
`define PIO_OFS_DAT 12'h000
`define PIO_OFS_DIR 12'h004
`define PIO_PAIR_STEP 12'h008
// high page: pullup, slew, drive, one 16-byte group per port
`define PIO_OFS_PE 12'h100
`define PIO_OFS_SE 12'h104
`define PIO_OFS_DS 12'h108
`define PIO_GRP_STEP 12'h010
// power mode status and control
`define PIO_OFS_PWR 12'h180
// power register bits
`define PIO_PWR_FLAG 0
`define PIO_PWR_ACK 1
`define PIO_PWR_HOLD 2
`define PIO_PWR_LIGHT 3
// reset values
`define PIO_RST_ZERO 8'h00
`define PIO_RST_SE 8'hFF
// port g pins five and six belong to the oscillator when it runs
`define PIO_OSC_MASK 8'h60
// port count and index of port g
`define PIO_NPORT 3
`define PIO_PORT_G 2

`endif

// [common/pio_pkg.sv]
// types shared by the parallel i/o block
// assumes pio_consts.svh sizes; ports are indexed e=0, f=1, g=2
package pio_pkg;

   // power sequence, one-hot
   typedef enum logic [2:0] {
      PIO_RUN = 3'b001,
      PIO_HOLD = 3'b010,
      PIO_WAKE = 3'b100
   } pio_pwr_e;

   // register kinds reached by the decoder
   typedef enum logic [2:0] {
      PIO_K_DAT = 3'h0,
      PIO_K_DIR = 3'h1,
      PIO_K_PE = 3'h2,
      PIO_K_SE = 3'h3,
      PIO_K_DS = 3'h4,
      PIO_K_PWR = 3'h5
   } pio_kind_e;

   // decoded address
   typedef struct packed {
      logic hit;
      pio_kind_e kind;
      logic [1:0] port;
   } pio_dec_s;

   // whole state of the top module
   typedef struct packed {
      logic [2:0][7:0] dat;
      logic [2:0][7:0] dir;
      logic [2:0][7:0] pe;
      logic [2:0][7:0] se;
      logic [2:0][7:0] ds;
      logic [2:0][7:0] pout;
      logic [2:0][7:0] poen_n;
      logic [2:0][7:0] ppu;
      logic [2:0][7:0] psl;
      logic [2:0][7:0] pdr;
      pio_pwr_e pwr;
      logic pd_flag;
      logic [31:0] prdata;
   } pio_state_s;

   // synchroniser state
   typedef struct packed {
      logic [2:0][7:0] s1;
      logic [2:0][7:0] s2;
   } pio_sync_s;

endpackage

// [rtl/pio_cell.sv]
// per-port pin control: override priority, pad controls, read-back
// assumes all inputs steady in core_clk domain; purely combinational
`timescale 1ns/1ps
`default_nettype none

module pio_cell (
   input wire logic [7:0] dir,
   input wire logic [7:0] dat,
   input wire logic [7:0] pe,
   input wire logic [7:0] se,
   input wire logic [7:0] ds,
   input wire logic [7:0] pen,
   input wire logic [7:0] poe,
   input wire logic [7:0] pdo,
   input wire logic [7:0] ana,
   input wire logic [7:0] own,
   input wire logic [7:0] key,
   input wire logic [7:0] pin,
   output logic [7:0] drv,
   output logic [7:0] out,
   output logic [7:0] pu,
   output logic [7:0] sl,
   output logic [7:0] dr,
   output logic [7:0] rb
);

   // ==========================================================
   // override priority
   logic [7:0] off; // digital logic fully off
   logic [7:0] dig; // digital peripheral in charge
   logic [7:0] kin; // keyboard input forces input

   // analog first, then oscillator, then peripheral, then port
   always_comb begin
      off = ana | own;
      dig = pen & ~off;
      kin = key & ~off & ~pen;
      // direction: peripheral wins over the port bit
      drv = ~off & ((dig & poe) | (~dig & ~kin & dir));
      // data: peripheral value on its own outputs
      out = (dig & pdo) | (~dig & dat);
      // pullup never on a driven or analog pin
      pu = pe & ~drv & ~off;
      // slew only means something on an output
      sl = se & drv;
      // drive strength straight from its bit unless pin is taken
      dr = ds & ~off;
      // read-back chosen by the port bit alone, analog reads zero
      rb = ~ana & ((dir & dat) | (~dir & pin));
   end

endmodule // pio_cell

`default_nettype wire

// [rtl/pio_sync.sv]
// two-flop synchroniser for all pad inputs
// assumes pads are asynchronous to core_clk
`timescale 1ns/1ps
`default_nettype none

module pio_sync (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [2:0][7:0] raw,
   output logic [2:0][7:0] sync
);

   // ==========================================================
   // state
   pio_pkg::pio_sync_s r_reg; // both stages
   pio_pkg::pio_sync_s r_next; // next stages

   // first stage only feeds the second
   always_comb begin
      r_next = r_reg;
      r_next.s1 = raw;
      r_next.s2 = r_reg.s1;
   end

   // synchronous reset to zero
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign sync = r_reg.s2;

endmodule // pio_sync

`default_nettype wire

// [rtl/pio_top.sv]
// parallel i/o ports e, f, g with pin control and apb registers
// assumes zero-wait apb master on core_clk, pads outside the block
//
// Behaviour
// - enabled peripheral sets pin direction
// - peripheral output value drives its pins
// - keyboard pins on port g are inputs unless a peripheral is enabled on them
// - running oscillator owns port g five, six
// - direction 0: driver off, read pin
// - direction 1: driver on, read latch
// - read-back follows direction bit despite overrides
// - analog pin: digital off, reads zero
// - analog beats digital peripheral on pin
// - pullup by bit, off when output/analog
// - slew by bit, no effect on inputs
// - drive bit selects high or low strength
// - pin control independent of data/direction
// - partial powerdown stop holds pad latches
// - light stop keeps all state
// - data/direction page zero, control high page
// - reset: inputs, slew on, pullups off
// - data writes latch all bits; reset clears
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "pio_consts.svh"
`default_nettype none

module pio_top (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [2:0][7:0] pin_i,
   output logic [2:0][7:0] pin_o,
   output logic [2:0][7:0] pin_oe_n,
   output logic [2:0][7:0] pin_pullup,
   output logic [2:0][7:0] pin_slew,
   output logic [2:0][7:0] pin_drive_hi,
   output logic [2:0][7:0] pin_sync,
   input wire logic [2:0][7:0] periph_en,
   input wire logic [2:0][7:0] periph_oe,
   input wire logic [2:0][7:0] periph_out,
   input wire logic [2:0][7:0] analog_en,
   input wire logic [7:0] keyboard_en,
   input wire logic osc_en,
   input wire logic ppd_stop,
   input wire logic light_stop
);

   // ==========================================================
   // address decode
   // one function serves both the read and the write path
   function automatic pio_pkg::pio_dec_s f_dec(input logic [11:0] a);
      pio_pkg::pio_dec_s d;
      logic [1:0] p;
      d = '0;
      p = 2'h0;
      for (int i = 0; i < `PIO_NPORT; i++) begin
         p = 2'(i);
         // page zero pair
         if (a == `PIO_OFS_DAT + 12'(i) * `PIO_PAIR_STEP) begin
            d = '{1'b1, pio_pkg::PIO_K_DAT, p};
         end
         if (a == `PIO_OFS_DIR + 12'(i) * `PIO_PAIR_STEP) begin
            d = '{1'b1, pio_pkg::PIO_K_DIR, p};
         end
         // high page group
         if (a == `PIO_OFS_PE + 12'(i) * `PIO_GRP_STEP) begin
            d = '{1'b1, pio_pkg::PIO_K_PE, p};
         end
         if (a == `PIO_OFS_SE + 12'(i) * `PIO_GRP_STEP) begin
            d = '{1'b1, pio_pkg::PIO_K_SE, p};
         end
         if (a == `PIO_OFS_DS + 12'(i) * `PIO_GRP_STEP) begin
            d = '{1'b1, pio_pkg::PIO_K_DS, p};
         end
      end
      if (a == `PIO_OFS_PWR) begin
         d = '{1'b1, pio_pkg::PIO_K_PWR, 2'h0};
      end
      return d;
   endfunction

   // ==========================================================
   // state and wires
   pio_pkg::pio_state_s r_reg; // all state
   pio_pkg::pio_state_s r_next; // next state
   pio_pkg::pio_dec_s dec; // current address decode
   logic wr_go; // write completes this edge
   logic rd_setup; // read setup cycle
   logic ack_wr; // software acknowledge write
   logic [2:0][7:0] own; // pins taken by the oscillator
   logic [2:0][7:0] key_in; // keyboard enables per port
   logic [2:0][7:0] c_drv; // cell direction
   logic [2:0][7:0] c_out; // cell output value
   logic [2:0][7:0] c_pu; // cell pullup
   logic [2:0][7:0] c_sl; // cell slew
   logic [2:0][7:0] c_dr; // cell drive strength
   logic [2:0][7:0] c_rb; // cell read-back

   // ==========================================================
   // system-owned pins and keyboard enables
   // only port g carries oscillator and keyboard functions
   always_comb begin
      own = '0;
      key_in = '0;
      own[`PIO_PORT_G] = osc_en ? `PIO_OSC_MASK : `PIO_RST_ZERO;
      key_in[`PIO_PORT_G] = keyboard_en;
   end

   // ==========================================================
   // synchroniser and per-port cells
   pio_sync u_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .raw(pin_i),
      .sync(pin_sync)
   );

   for (genvar g = 0; g < `PIO_NPORT; g++) begin : g_port
      pio_cell u_cell (
         .dir(r_reg.dir[g]),
         .dat(r_reg.dat[g]),
         .pe(r_reg.pe[g]),
         .se(r_reg.se[g]),
         .ds(r_reg.ds[g]),
         .pen(periph_en[g]),
         .poe(periph_oe[g]),
         .pdo(periph_out[g]),
         .ana(analog_en[g]),
         .own(own[g]),
         .key(key_in[g]),
         .pin(pin_sync[g]),
         .drv(c_drv[g]),
         .out(c_out[g]),
         .pu(c_pu[g]),
         .sl(c_sl[g]),
         .dr(c_dr[g]),
         .rb(c_rb[g])
      );
   end

   // ==========================================================
   // apb handshake
   // zero wait states; unmapped addresses answer with an error
   always_comb begin
      dec = f_dec(paddr);
      wr_go = psel & penable & pwrite & dec.hit;
      rd_setup = psel & ~penable & ~pwrite;
      ack_wr = wr_go & (dec.kind == pio_pkg::PIO_K_PWR) & pwdata[`PIO_PWR_ACK];
   end

   assign pready = 1'b1;
   assign pslverr = psel & penable & ~dec.hit;

   // ==========================================================
   // next state
   always_comb begin
      r_next = r_reg;
      // register writes, each group touches only its own bits
      if (wr_go) begin
         unique case (dec.kind)
            pio_pkg::PIO_K_DAT: begin
               r_next.dat[dec.port] = pwdata[7:0];
            end
            pio_pkg::PIO_K_DIR: begin
               r_next.dir[dec.port] = pwdata[7:0];
            end
            pio_pkg::PIO_K_PE: begin
               r_next.pe[dec.port] = pwdata[7:0];
            end
            pio_pkg::PIO_K_SE: begin
               r_next.se[dec.port] = pwdata[7:0];
            end
            pio_pkg::PIO_K_DS: begin
               r_next.ds[dec.port] = pwdata[7:0];
            end
            default: begin
               // power register: acknowledge handled below
            end
         endcase
      end
      // read data captured in setup so prdata comes from a flop
      if (rd_setup) begin
         r_next.prdata = 32'h0000_0000;
         if (dec.hit) begin
            unique case (dec.kind)
               pio_pkg::PIO_K_DAT: r_next.prdata[7:0] = c_rb[dec.port];
               pio_pkg::PIO_K_DIR: r_next.prdata[7:0] = r_reg.dir[dec.port];
               pio_pkg::PIO_K_PE: r_next.prdata[7:0] = r_reg.pe[dec.port];
               pio_pkg::PIO_K_SE: r_next.prdata[7:0] = r_reg.se[dec.port];
               pio_pkg::PIO_K_DS: r_next.prdata[7:0] = r_reg.ds[dec.port];
               default: begin
                  r_next.prdata[`PIO_PWR_FLAG] = r_reg.pd_flag;
                  r_next.prdata[`PIO_PWR_HOLD] = (r_reg.pwr != pio_pkg::PIO_RUN);
                  r_next.prdata[`PIO_PWR_LIGHT] = light_stop;
               end
            endcase
         end
      end
      // power sequence; light stop needs nothing, all keeps running
      unique case (r_reg.pwr)
         pio_pkg::PIO_RUN: begin
            if (ppd_stop) begin
               r_next.pwr = pio_pkg::PIO_HOLD;
            end
         end
         pio_pkg::PIO_HOLD: begin
            if (!ppd_stop) begin
               r_next.pwr = pio_pkg::PIO_WAKE;
               r_next.pd_flag = 1'b1;
            end
         end
         pio_pkg::PIO_WAKE: begin
            // pads stay frozen until software acknowledges
            if (ack_wr) begin
               r_next.pwr = pio_pkg::PIO_RUN;
               r_next.pd_flag = 1'b0;
            end
         end
         default: begin
            r_next.pwr = pio_pkg::PIO_RUN;
         end
      endcase
      // pad flops follow the cells only while running
      if (r_reg.pwr == pio_pkg::PIO_RUN && !ppd_stop) begin
         r_next.pout = c_out;
         r_next.poen_n = ~c_drv;
         r_next.ppu = c_pu;
         r_next.psl = c_sl;
         r_next.pdr = c_dr;
      end
   end

   // ==========================================================
   // register the state, synchronous reset
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         r_reg <= '0;
         r_reg.se <= {`PIO_NPORT{`PIO_RST_SE}};
         r_reg.poen_n <= '1;
         r_reg.pwr <= pio_pkg::PIO_RUN;
      end else begin
         r_reg <= r_next;
      end
   end

   // ==========================================================
   // outputs
   assign prdata = r_reg.prdata;
   assign pin_o = r_reg.pout;
   assign pin_oe_n = r_reg.poen_n;
   assign pin_pullup = r_reg.ppu;
   assign pin_slew = r_reg.psl;
   assign pin_drive_hi = r_reg.pdr;

   // ==========================================================
   // checks
   chk_analog_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
      ((analog_en[1] & (c_drv[1] | c_rb[1] | c_pu[1])) == 8'h00))
      else $error("analog pin still driven or read");

   chk_key_input: assert property (@(posedge core_clk) disable iff (!rst_n)
      ((keyboard_en & ~periph_en[2] & c_drv[2]) == 8'h00))
      else $error("keyboard pin driven");

   chk_osc_owns: assert property (@(posedge core_clk) disable iff (!rst_n)
      osc_en |-> ((c_drv[2] | c_pu[2] | c_dr[2]) & `PIO_OSC_MASK) == 8'h00)
      else $error("oscillator pins not released");

   chk_periph_data: assert property (@(posedge core_clk) disable iff (!rst_n)
      (((periph_en[1] & ~analog_en[1]) & (c_drv[1] ^ periph_oe[1])) == 8'h00)
      && (((periph_en[1] & ~analog_en[1]) & (c_out[1] ^ periph_out[1])) == 8'h00))
      else $error("peripheral not in control");

   chk_pullup_off: assert property (@(posedge core_clk) disable iff (!rst_n)
      ((c_pu[0] & c_drv[0]) == 8'h00) && ((c_sl[0] & ~c_drv[0]) == 8'h00))
      else $error("pullup or slew on wrong pin");

   chk_read_back: assert property (@(posedge core_clk) disable iff (!rst_n)
      (psel && !penable && !pwrite && paddr == `PIO_OFS_DAT)
      |=> prdata[7:0] == ((($past(r_reg.dir[0]) & $past(r_reg.dat[0]))
      | (~$past(r_reg.dir[0]) & $past(pin_sync[0]))) & ~$past(analog_en[0])))
      else $error("port data read-back wrong");

   chk_dir_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      (psel && penable && pwrite && paddr == `PIO_OFS_DIR)
      |=> r_reg.dir[0] == $past(pwdata[7:0]) && $stable(r_reg.pe))
      else $error("direction write lost or leaked");

   chk_hold_pads: assert property (@(posedge core_clk) disable iff (!rst_n)
      (r_reg.pwr == pio_pkg::PIO_HOLD) |=> $stable(pin_o) && $stable(pin_oe_n))
      else $error("pads moved in partial powerdown");

   chk_wake_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
      (r_reg.pwr == pio_pkg::PIO_HOLD && !ppd_stop)
      |=> r_reg.pd_flag ##1 (r_reg.pwr == pio_pkg::PIO_WAKE || ack_wr || $past(ack_wr)))
      else $error("wake flag not raised");

   chk_reset_vals: assert property (@(posedge core_clk)
      !rst_n |=> r_reg.dir == '0 && r_reg.se == '1 && r_reg.pe == '0 && pin_oe_n == '1)
      else $error("reset values wrong");

endmodule // pio_top

`default_nettype wire

// [verification/pio_pad_model.sv]
// pad and board model for the parallel i/o block: resolves each pad level
// assumes the bench chooses which pads the board drives, and the values
`timescale 1ns/1ps
`default_nettype none

module pio_pad_model (
   input wire logic core_clk,
   input wire logic [2:0][7:0] pin_o,
   input wire logic [2:0][7:0] pin_oe_n,
   input wire logic [2:0][7:0] pin_pullup,
   input wire logic [2:0][7:0] ext_en,
   input wire logic [2:0][7:0] ext_val,
   output logic [2:0][7:0] pad
);
   // =====================================================
   // floating pads
   // a pad nobody drives toggles each cycle, so a stale value cannot pass
   logic [2:0][7:0] flt = '0;
   always_ff @(posedge core_clk) begin
      flt <= ~flt;
   end
   // =====================================================
   // level resolution: device driver, then board, then pullup
   always_comb begin
      for (int p = 0; p < 3; p++) begin
         for (int b = 0; b < 8; b++) begin
            if (!pin_oe_n[p][b]) begin
               pad[p][b] = pin_o[p][b];
            end else if (ext_en[p][b]) begin
               pad[p][b] = ext_val[p][b];
            end else if (pin_pullup[p][b]) begin
               pad[p][b] = 1'b1;
            end else begin
               pad[p][b] = flt[p][b];
            end
         end
      end
   end
endmodule // pio_pad_model
`default_nettype wire

// [verification/tb.sv]
// self-checking bench for pio_top: apb master, peripheral and pad stimulus
// assumes pio_pad_model resolves pads; ports indexed e=0, f=1, g=2
`timescale 1ns/1ps
`include "pio_consts.svh"
`default_nettype none

module tb;
   // =====================================================
   // signals
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd_d;
   logic pready, pslverr, rd_e;
   logic [2:0][7:0] pad, pin_o, pin_oe_n, pin_pullup, pin_slew, pin_drive_hi, pin_sync;
   logic [2:0][7:0] periph_en = '0, periph_oe = '0, periph_out = '0, analog_en = '0;
   logic [2:0][7:0] ext_en = '0, ext_val = '0;
   logic [7:0] keyboard_en = '0;
   logic osc_en = 1'b0, ppd_stop = 1'b0, light_stop = 1'b0;
   int errors = 0;
   int tests_run = 0;

   pio_top pio_top_inst (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_i(pad),
      .pin_o(pin_o), .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup),
      .pin_slew(pin_slew), .pin_drive_hi(pin_drive_hi), .pin_sync(pin_sync),
      .periph_en(periph_en), .periph_oe(periph_oe), .periph_out(periph_out),
      .analog_en(analog_en), .keyboard_en(keyboard_en), .osc_en(osc_en),
      .ppd_stop(ppd_stop), .light_stop(light_stop));
   pio_pad_model pio_pad_model_inst (.core_clk(core_clk), .pin_o(pin_o),
      .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup), .ext_en(ext_en),
      .ext_val(ext_val), .pad(pad));

   // =====================================================
   // clock and watchdog
   initial begin
      forever #20 core_clk = ~core_clk;
   end
   // whole run is well under a thousand cycles
   initial begin
      repeat (4000) @(posedge core_clk);
      errors++;
      stop_test();
   end

   // =====================================================
   // shared tasks
   task automatic stop_test();
      if (errors == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      tests_run++;
      if (s !== e) begin
         errors++;
         $display("FAIL %0t got %h expected %h", $time, s, e);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // address of one register of port p
   function automatic logic [11:0] ad(input logic [11:0] ofs, input logic [11:0] st,
         input logic [1:0] p);
      return ofs + st * {10'h000, p};
   endfunction
   // one apb transfer; waits for pready, then releases
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0000_00, d};
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd_d = prdata;
      rd_e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      chk(rd_d[7:0], e);
   endtask

   // =====================================================
   // scenarios
   task automatic t_reset();
      for (int p = 0; p < 3; p++) begin
         rdchk(ad(`PIO_OFS_DIR, `PIO_PAIR_STEP, 2'(p)), `PIO_RST_ZERO);
         rdchk(ad(`PIO_OFS_PE, `PIO_GRP_STEP, 2'(p)), `PIO_RST_ZERO);
         rdchk(ad(`PIO_OFS_SE, `PIO_GRP_STEP, 2'(p)), `PIO_RST_SE);
         rdchk(ad(`PIO_OFS_DS, `PIO_GRP_STEP, 2'(p)), `PIO_RST_ZERO);
         chk(pin_oe_n[p], 8'hFF);
         chk(pin_pullup[p], 8'h00);
      end
      // cleared data is seen once the pins turn to outputs
      wr(ad(`PIO_OFS_DIR, `PIO_PAIR_STEP, 2'd2), 8'hFF);
      tick(3);
      chk(pin_o[2], 8'h00);
      rdchk(ad(`PIO_OFS_DAT, `PIO_PAIR_STEP, 2'd2), 8'h00);
      wr(ad(`PIO_OFS_DIR, `PIO_PAIR_STEP, 2'd2), 8'h00);
   endtask
   task automatic t_dir();
      ext_en[0] <= 8'hFF;
      ext_val[0] <= 8'h3C;
      // data first, direction after
      wr(`PIO_OFS_DAT, 8'hA5);
      tick(5);
      rdchk(`PIO_OFS_DAT, 8'h3C);
      chk(pin_oe_n[0], 8'hFF);
      wr(`PIO_OFS_DIR, 8'hFF);
      tick(5);
      chk(pin_oe_n[0], 8'h00);
      chk(pin_o[0], 8'hA5);
      chk(pin_sync[0], 8'hA5);
      rdchk(`PIO_OFS_DAT, 8'hA5);
      wr(`PIO_OFS_DIR, 8'hF0);
      tick(5);
      rdchk(`PIO_OFS_DAT, 8'hAC);
   endtask
   task automatic t_periph();
      ext_en[1] <= 8'h03;
      ext_val[1] <= 8'h01;
      wr(ad(`PIO_OFS_DAT, `PIO_PAIR_STEP, 2'd1), 8'hF0);
      wr(ad(`PIO_OFS_DIR, `PIO_PAIR_STEP, 2'd1), 8'hF0);
      wr(ad(`PIO_OFS_PE, `PIO_GRP_STEP, 2'd1), 8'hFF);
      periph_en[1] <= 8'h3C;
      periph_oe[1] <= 8'h0C;
      periph_out[1] <= 8'h08;
      tick(5);
      chk(pin_oe_n[1], 8'h33);
      chk(pin_o[1] & 8'hCC, 8'hC8);
      chk(pin_pullup[1], 8'h33);
      rdchk(ad(`PIO_OFS_DAT, `PIO_PAIR_STEP, 2'd1), 8'hF9);
      // analog on a port-driven and a peripheral-driven pin
      analog_en[1] <= 8'h88;
      tick(5);
      chk(pin_oe_n[1], 8'hBB);
      chk(pin_pullup[1], 8'h33);
      rdchk(ad(`PIO_OFS_DAT, `PIO_PAIR_STEP, 2'd1), 8'h71);
      analog_en[1] <= 8'h00;
      periph_en[1] <= 8'h00;
   endtask
   task automatic t_portg();
      wr(ad(`PIO_OFS_DAT, `PIO_PAIR_STEP, 2'd2), 8'hFF);
      wr(ad(`PIO_OFS_DIR, `PIO_PAIR_STEP, 2'd2), 8'hFF);
      wr(ad(`PIO_OFS_PE, `PIO_GRP_STEP, 2'd2), 8'hFF);
      wr(ad(`PIO_OFS_DS, `PIO_GRP_STEP, 2'd2), 8'hFF);
      keyboard_en <= 8'h01;
      osc_en <= 1'b1;
      tick(3);
      chk(pin_oe_n[2], 8'h01 | `PIO_OSC_MASK);
      chk(pin_pullup[2], 8'h01);
      chk(pin_drive_hi[2], ~`PIO_OSC_MASK);
      keyboard_en <= 8'h00;
      osc_en <= 1'b0;
      tick(3);
      chk(pin_oe_n[2], 8'h00);
   endtask
   task automatic t_ctrl();
      wr(`PIO_OFS_SE, 8'h3C);
      wr(`PIO_OFS_DS, 8'h3C);
      wr(`PIO_OFS_PE, 8'hFF);
      tick(3);
      chk(pin_slew[0], 8'h30);
      chk(pin_drive_hi[0], 8'h3C);
      chk(pin_pullup[0], 8'h0F);
      rdchk(`PIO_OFS_DIR, 8'hF0);
      rdchk(`PIO_OFS_DAT, 8'hAC);
      rdchk(`PIO_OFS_SE, 8'h3C);
   endtask
   task automatic t_map();
      wr(12'h040, 8'hFF);
      chk({7'h00, rd_e}, 8'h01);
      chk({7'h00, pready}, 8'h01);
      rdchk(12'h040, 8'h00);
      chk({7'h00, rd_e}, 8'h01);
      rdchk(`PIO_OFS_DIR, 8'hF0);
      chk({7'h00, rd_e}, 8'h00);
   endtask
   task automatic t_power();
      ppd_stop <= 1'b1;
      tick(2);
      wr(`PIO_OFS_DAT, 8'h5A);
      tick(3);
      chk(pin_o[0] & 8'hF0, 8'hA0);
      rdchk(`PIO_OFS_PWR, 8'h04);
      ppd_stop <= 1'b0;
      tick(2);
      // flag is examined before any i/o access, then acknowledged
      rdchk(`PIO_OFS_PWR, 8'h05);
      chk(pin_o[0] & 8'hF0, 8'hA0);
      wr(`PIO_OFS_PWR, 8'h02);
      tick(3);
      chk(pin_o[0] & 8'hF0, 8'h50);
      rdchk(`PIO_OFS_PWR, 8'h00);
      light_stop <= 1'b1;
      tick(2);
      rdchk(`PIO_OFS_PWR, 8'h08);
      chk(pin_o[0] & 8'hF0, 8'h50);
      light_stop <= 1'b0;
   endtask

   // =====================================================
   // main sequence
   initial begin
      tick(16);
      rst_n <= 1'b1;
      t_reset();
      t_dir();
      t_periph();
      t_portg();
      t_ctrl();
      t_map();
      t_power();
      tick(2);
      stop_test();
   end
endmodule // tb
`default_nettype wire
